// [logic/aslo_regs.vh]
/*
  constants for the serial lvds output block: modes, widths, latencies.
  assumes inclusion by aslo_top.v only; definitions only.
*/
`ifndef ASLO_REGS_VH
`define ASLO_REGS_VH
// ==========================================================
// output wire modes
`define ASLO_WIRE_TWO      2'h0
`define ASLO_WIRE_ONE      2'h1
`define ASLO_WIRE_HALF     2'h2
// ==========================================================
// decimation modes
`define ASLO_DEC_OFF       2'h0
`define ASLO_DEC_REAL2     2'h1
`define ASLO_DEC_CPLX2     2'h2
`define ASLO_DEC_HIGH      2'h3
// ==========================================================
// latencies in output sample periods
`define ASLO_LAT_TWO       5'h02
`define ASLO_LAT_ONE       5'h01
`define ASLO_LAT_REAL2     5'h15
`define ASLO_LAT_CPLX2     5'h16
`define ASLO_LAT_HIGH      5'h17
`define ASLO_DLY_DEPTH     26
// ==========================================================
// bits per lane per output sample
`define ASLO_BITS_TWO      6'h08
`define ASLO_BITS_ONE      6'h10
`define ASLO_BITS_HALF     6'h20
`define ASLO_SAMPLE_W      16
`define ASLO_WORD_W        32
`define ASLO_LANES         4
// ==========================================================
// programming port
`define ASLO_SCLK_MAX_MHZ  20
`define ASLO_SCLK_MIN_PERIOD_NS (1000 / `ASLO_SCLK_MAX_MHZ)
`define ASLO_CLK_PERIOD_NS 5
`define ASLO_SCLK_MIN_CYC  (`ASLO_SCLK_MIN_PERIOD_NS / `ASLO_CLK_PERIOD_NS)
`define ASLO_SPI_HDR_BITS  4'h8
`define ASLO_SPI_LAST_BIT  4'hf
`endif

// [logic/aslo_top.v]
/*
  serial lvds output stage of a dual 16-bit converter with latency line,
  sync capture and a read-only serial programming port.
  assumes sample clock, bit clock, sync and the serial port pins are
  asynchronous to clk_in and much slower; samples come from clk_in logic.
*/
`timescale 1ns/10ps
`include "aslo_regs.vh"

module aslo_top
(
  input  wire        clk_in,
  input  wire        rstn_in,
  input  wire        sample_clk_in,
  input  wire        bit_clock_input_in,
  input  wire        sync_in,
  input  wire [15:0] ch_a_sample_in,
  input  wire [15:0] ch_b_sample_in,
  input  wire [1:0]  wire_mode_in,
  input  wire [1:0]  dec_mode_in,
  input  wire        sclk_in,
  input  wire        serial_enable_n_in,
  input  wire        sdio_in,
  output reg         output_bit_clock_out,
  output reg         lane_a_first_out,
  output reg         lane_a_second_out,
  output reg         lane_b_first_out,
  output reg         lane_b_second_out,
  output reg         sync_seen_out,
  output reg         sdio_out,
  output reg         sdio_oe_out
);

  // ==========================================================
  // pin synchronisers, two flops then one history flop
  reg  [5:0] meta_q;
  reg  [5:0] sync2_q;
  reg  [5:0] hist_q;
  wire       smp_rise;
  wire       smp_fall;
  wire       bck_rise;
  wire       bck_fall;
  wire       sck_rise;
  wire       sck_fall;
  wire       sync_lvl;
  wire       sen_lvl;
  wire       sdi_lvl;
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      meta_q  <= 6'h00;
      sync2_q <= 6'h00;
      hist_q  <= 6'h00;
    end
    else
    begin
      meta_q  <= {sdio_in, serial_enable_n_in, sclk_in, sync_in,
                  bit_clock_input_in, sample_clk_in};
      sync2_q <= meta_q;
      hist_q  <= sync2_q;
    end
  end
  assign smp_rise = sync2_q[0] & ~hist_q[0];
  assign smp_fall = ~sync2_q[0] & hist_q[0];
  assign bck_rise = sync2_q[1] & ~hist_q[1];
  assign bck_fall = ~sync2_q[1] & hist_q[1];
  assign sync_lvl = sync2_q[2];
  assign sck_rise = sync2_q[3] & ~hist_q[3];
  assign sck_fall = ~sync2_q[3] & hist_q[3];
  assign sen_lvl  = sync2_q[4];
  assign sdi_lvl  = sync2_q[5];

  // ==========================================================
  // latency line, one entry per sample period
  reg  [31:0] dly_q [0:`ASLO_DLY_DEPTH-1];
  reg  [4:0]  lat_tap;
  reg  [5:0]  bits_per;
  integer     i;
  always @*
  begin
    lat_tap = (wire_mode_in == `ASLO_WIRE_TWO) ? `ASLO_LAT_TWO
                                               : `ASLO_LAT_ONE;
    case (dec_mode_in)
      `ASLO_DEC_REAL2: lat_tap = lat_tap + `ASLO_LAT_REAL2;
      `ASLO_DEC_CPLX2: lat_tap = lat_tap + `ASLO_LAT_CPLX2;
      `ASLO_DEC_HIGH:  lat_tap = lat_tap + `ASLO_LAT_HIGH;
      default:         lat_tap = lat_tap;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      for (i = 0; i < `ASLO_DLY_DEPTH; i = i + 1)
        dly_q[i] <= 32'h0000_0000;
    end
    else if (smp_rise)
    begin
      dly_q[0] <= {ch_a_sample_in, ch_b_sample_in};
      for (i = 1; i < `ASLO_DLY_DEPTH; i = i + 1)
        dly_q[i] <= dly_q[i-1];
    end
  end
  wire [31:0] tap_word = dly_q[lat_tap];
  wire [15:0] tap_a    = tap_word[31:16];
  wire [15:0] tap_b    = tap_word[15:0];

  // ==========================================================
  // sync capture on the sampling clock rising edge
  reg sync_q;
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      sync_q        <= 1'b0;
      sync_seen_out <= 1'b0;
    end
    else if (smp_rise)
    begin
      sync_q        <= sync_lvl;
      sync_seen_out <= sync_lvl;
    end
  end

  // ==========================================================
  // lane load words and serialisers
  reg [31:0] load_w [0:`ASLO_LANES-1];
  always @*
  begin
    load_w[0] = 32'h0000_0000;
    load_w[1] = 32'h0000_0000;
    load_w[2] = 32'h0000_0000;
    load_w[3] = 32'h0000_0000;
    bits_per  = `ASLO_BITS_TWO;
    case (wire_mode_in)
      `ASLO_WIRE_TWO:
      begin
        load_w[0] = {tap_a[15:8], 24'h00_0000};
        load_w[1] = {tap_a[7:0], 24'h00_0000};
        load_w[2] = {tap_b[15:8], 24'h00_0000};
        load_w[3] = {tap_b[7:0], 24'h00_0000};
        bits_per  = `ASLO_BITS_TWO;
      end
      `ASLO_WIRE_ONE:
      begin
        load_w[0] = {tap_a, 16'h0000};
        load_w[2] = {tap_b, 16'h0000};
        bits_per  = `ASLO_BITS_ONE;
      end
      `ASLO_WIRE_HALF:
      begin
        load_w[0] = tap_word;
        bits_per  = `ASLO_BITS_HALF;
      end
      default:         bits_per  = `ASLO_BITS_TWO;
    endcase
  end

  reg  [5:0] bit_cnt_q;
  wire       frame_load = smp_fall | (smp_rise & sync_lvl & ~sync_q);
  wire       bit_go     = bck_rise & (bit_cnt_q != 6'h00);
  wire [3:0] lane_bit;
  always @(posedge clk_in)
  begin
    if (!rstn_in)
      bit_cnt_q <= 6'h00;
    // frame start on sample fall, sync realigns
    else if (frame_load)
      bit_cnt_q <= bits_per;
    else if (bit_go)
      bit_cnt_q <= bit_cnt_q - 6'h01;
  end
  genvar g;
  generate
    for (g = 0; g < `ASLO_LANES; g = g + 1)
    begin : g_lane
      reg [31:0] sr_q;
      reg        bit_q;
      always @(posedge clk_in)
      begin
        if (!rstn_in)
        begin
          sr_q  <= 32'h0000_0000;
          bit_q <= 1'b0;
        end
        else if (frame_load)
          sr_q  <= load_w[g];
        else if (bit_go)
        begin
          bit_q <= sr_q[31];
          sr_q  <= {sr_q[30:0], 1'b0};
        end
      end
      // bit leaves on the clock rise edge, not one cycle later
      assign lane_bit[g] = bit_go ? sr_q[31] : bit_q;
    end
  endgenerate

  // ==========================================================
  // output flops; data and clock move in the same cycle
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      output_bit_clock_out <= 1'b0;
      lane_a_first_out     <= 1'b0;
      lane_a_second_out    <= 1'b0;
      lane_b_first_out     <= 1'b0;
      lane_b_second_out    <= 1'b0;
    end
    else
    begin
      // clock derived from bit clock input
      if (bck_rise)
        output_bit_clock_out <= 1'b1;
      else if (bck_fall)
        output_bit_clock_out <= 1'b0;
      lane_a_first_out  <= lane_bit[0];
      lane_a_second_out <= lane_bit[1];
      lane_b_first_out  <= lane_bit[2];
      lane_b_second_out <= lane_bit[3];
    end
  end

  // ==========================================================
  // serial programming port, read-only status byte
  reg  [3:0] spi_cnt_q;
  reg  [7:0] spi_hdr_q;
  wire [7:0] status_byte = {sync_q, 1'b0, dec_mode_in, 2'h0, wire_mode_in};
  wire       spi_read    = spi_hdr_q[7];

  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      spi_cnt_q   <= 4'h0;
      spi_hdr_q   <= 8'h00;
      sdio_out    <= 1'b0;
      sdio_oe_out <= 1'b0;
    end
    else if (sen_lvl)
    begin
      spi_cnt_q   <= 4'h0;
      spi_hdr_q   <= 8'h00;
      sdio_oe_out <= 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        if (spi_cnt_q < `ASLO_SPI_HDR_BITS)
          spi_hdr_q <= {spi_hdr_q[6:0], sdi_lvl};
        if (spi_cnt_q != `ASLO_SPI_LAST_BIT)
          spi_cnt_q <= spi_cnt_q + 4'h1;
      end
      if (sck_fall && spi_read && spi_cnt_q >= `ASLO_SPI_HDR_BITS)
      begin
        sdio_oe_out <= 1'b1;
        sdio_out    <= status_byte[3'h7 - spi_cnt_q[2:0]];
      end
      else if (sck_fall)
        sdio_oe_out <= 1'b0;
    end
  end

endmodule // aslo_top

// [dv/aslo_checker.sv]
/*
  port assertions for aslo_top, bound below.
  assumes pin edges are slow against clk_in.
*/
`timescale 1ns/10ps
module aslo_checker
(
  input wire       clk_in,
  input wire       rstn_in,
  input wire       sample_clk_in,
  input wire       bit_clock_input_in,
  input wire       sync_in,
  input wire [1:0] wire_mode_in,
  input wire       sclk_in,
  input wire       serial_enable_n_in,
  input wire       output_bit_clock_out,
  input wire       lane_a_first_out,
  input wire       lane_a_second_out,
  input wire       lane_b_first_out,
  input wire       lane_b_second_out,
  input wire       sync_seen_out,
  input wire       sdio_out,
  input wire       sdio_oe_out
);
  // ==========================================================
  // mode age
  reg [10:0] age_q;
  reg [1:0]  mode_q;
  always @(posedge clk_in)
  begin
    mode_q <= wire_mode_in;
    if (!rstn_in || mode_q != wire_mode_in)
      age_q <= 11'h0;
    else if (age_q != 11'h7ff)
      age_q <= age_q + 11'h1;
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  obc_rise_a:
    assert property ($rose(bit_clock_input_in) |-> ##[2:6] output_bit_clock_out)
      else $error("bit clock rise not followed");
  obc_fall_a:
    assert property ($fell(bit_clock_input_in) |-> ##[2:6] !output_bit_clock_out)
      else $error("bit clock fall not followed");
  lane_launch_a:
    assert property ($changed(lane_a_first_out) |-> $rose(output_bit_clock_out))
      else $error("lane moved off bit clock rise");
  oe_rise_a:
    assert property ($rose(sdio_oe_out) |-> !sclk_in && !serial_enable_n_in)
      else $error("sdio driven at wrong time");
  sdio_change_a:
    assert property ($changed(sdio_out) |-> !sclk_in)
      else $error("sdio changed while sclk high");
  oe_release_a:
    assert property ($rose(serial_enable_n_in) |-> ##[1:6] !sdio_oe_out)
      else $error("sdio not released");
  sync_capture_a:
    assert property ($changed(sync_seen_out)
      |-> sample_clk_in && sync_seen_out == sync_in)
      else $error("sync captured off sample rise");
  spare_lanes_a:
    assert property (age_q == 11'h3e8 && wire_mode_in != 2'h0
      |-> !(lane_a_second_out | lane_b_second_out
            | (wire_mode_in == 2'h2 & lane_b_first_out)))
      else $error("unused lane not idle");
  cover property ($rose(sdio_oe_out));
  cover property ($rose(sync_seen_out));
  cover property (age_q == 11'h3e8 && wire_mode_in == 2'h2);
endmodule // aslo_checker

bind aslo_top aslo_checker chk_u (.*);

// [dv/aslo_rx_model.sv]
/*
  receiver model: makes the bit clock per frame, captures lanes.
  assumes lanes ordered a1, a2, b1, b2 from bit 0.
*/
`timescale 1ns/10ps
module aslo_rx_model
(
  input  wire         sample_clk_in,
  input  wire [1:0]   wire_mode_in,
  input  wire         output_bit_clock_in,
  input  wire [3:0]   lanes_in,
  output reg          bit_clock_out,
  output reg  [127:0] cap_out
);
  integer i;
  initial bit_clock_out = 1'b0;
  always @(negedge sample_clk_in)
  begin
    // off the 5 ns grid so edges never tie clk_in
    #21;
    repeat (wire_mode_in == 2'h0 ? 8 : wire_mode_in == 2'h1 ? 16 : 32)
    begin
      bit_clock_out = 1'b1;
      #40 bit_clock_out = 1'b0;
      #40;
    end
  end
  always @(negedge output_bit_clock_in)
    for (i = 0; i < 4; i = i + 1)
      cap_out[32*i +: 32] <= {cap_out[32*i +: 31], lanes_in[i]};
endmodule // aslo_rx_model

// [dv/tb_aslo_top.sv]
/*
  self-checking bench for aslo_top with receiver model.
  assumes 200 MHz clk_in; latency counted in sample periods.
*/
`timescale 1ns/10ps
module tb_aslo_top;
  localparam [23:0] CFG = 24'h048563;
  reg          clk_in = 1'b0;
  reg          rstn_in = 1'b0;
  reg          sample_clk_in = 1'b0;
  reg          sync_in = 1'b0;
  reg  [15:0]  ch_a_sample_in = 16'h0;
  reg  [15:0]  ch_b_sample_in = 16'h0;
  reg  [1:0]   wire_mode_in = 2'h0;
  reg  [1:0]   dec_mode_in = 2'h0;
  reg          sclk_in = 1'b0;
  reg          serial_enable_n_in = 1'b1;
  reg          host_q = 1'b0;
  wire         bclk;
  wire         obc;
  wire [3:0]   lanes;
  wire         sync_seen_out;
  wire         sdio_out;
  wire         sdio_oe_out;
  wire         sdio_w = sdio_oe_out ? sdio_out : host_q;
  wire [127:0] cap;
  reg  [31:0]  q [$];
  reg  [31:0]  w;
  reg  [31:0]  e;
  reg  [7:0]   rd;
  reg  [3:0]   m;
  integer      seed = 94185;
  integer      error_cnt = 0;
  integer      num_checks = 0;
  integer      tap;
  integer      c;
  initial forever #2.5 clk_in = ~clk_in;
  aslo_top dut_u
  (
    .clk_in               (clk_in),
    .rstn_in              (rstn_in),
    .sample_clk_in        (sample_clk_in),
    .bit_clock_input_in   (bclk),
    .sync_in              (sync_in),
    .ch_a_sample_in       (ch_a_sample_in),
    .ch_b_sample_in       (ch_b_sample_in),
    .wire_mode_in         (wire_mode_in),
    .dec_mode_in          (dec_mode_in),
    .sclk_in              (sclk_in),
    .serial_enable_n_in   (serial_enable_n_in),
    .sdio_in              (sdio_w),
    .output_bit_clock_out (obc),
    .lane_a_first_out     (lanes[0]),
    .lane_a_second_out    (lanes[1]),
    .lane_b_first_out     (lanes[2]),
    .lane_b_second_out    (lanes[3]),
    .sync_seen_out        (sync_seen_out),
    .sdio_out             (sdio_out),
    .sdio_oe_out          (sdio_oe_out)
  );
  aslo_rx_model rx_u
  (
    .sample_clk_in       (sample_clk_in),
    .wire_mode_in        (wire_mode_in),
    .output_bit_clock_in (obc),
    .lanes_in            (lanes),
    .bit_clock_out       (bclk),
    .cap_out             (cap)
  );
  // ==========================================================
  // helpers
  task check(input [31:0] seen, input [31:0] exp, input [47:0] name);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected %0s exp %h seen %h", name, exp, seen);
    end
  end
  endtask
  function [31:0] sw(input [1:0] md);
  begin
    if (md == 2'h0)
      sw = {cap[7:0], cap[39:32], cap[71:64], cap[103:96]};
    else if (md == 2'h1)
      sw = {cap[15:0], cap[79:64]};
    else
      sw = cap[31:0];
  end
  endfunction
  task frame;
  begin
    w = $random(seed);
    q.push_back(w);
    sample_clk_in <= 1'b1;
    ch_a_sample_in <= w[31:16];
    ch_b_sample_in <= w[15:0];
    repeat (320) @(posedge clk_in);
    if (q.size() >= tap + 3)
    begin
      e = q[q.size() - 2 - tap];
      check(sw(wire_mode_in), e, "lanes");
    end
    sample_clk_in <= 1'b0;
    repeat (320) @(posedge clk_in);
  end
  endtask
  // host clock 10 MHz, below the limit
  // a write header leaves the pin released and reads back host zeros
  task spi_xfer(input rnw);
    integer k;
  begin
    serial_enable_n_in <= 1'b0;
    for (k = 0; k < 16; k = k + 1)
    begin
      host_q <= rnw & (k == 0);
      repeat (10) @(posedge clk_in);
      sclk_in <= 1'b1;
      rd = {rd[6:0], sdio_w};
      repeat (10) @(posedge clk_in);
      sclk_in <= 1'b0;
    end
    check(sdio_oe_out, rnw, "oe");
    repeat (10) @(posedge clk_in);
    serial_enable_n_in <= 1'b1;
    e = {24'h00_0000, sync_in, 1'b0, dec_mode_in, 2'h0, wire_mode_in};
    check(rd, rnw ? e : 32'h0000_0000, "status");
    repeat (10) @(posedge clk_in);
    check(sdio_oe_out, 1'b0, "oe");
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (c = 0; c < 6; c = c + 1)
    begin
      m = CFG[23 - 4 * c -: 4];
      wire_mode_in <= m[3:2];
      dec_mode_in <= m[1:0];
      tap = (m[3:2] == 2'h0 ? 2 : 1) + (m[1:0] == 2'h0 ? 0 : 20 + m[1:0]);
      q.delete();
      repeat (tap + 5) frame;
      spi_xfer(1'b1);
      $display("mode test wire %0d dec %0d done", m[3:2], m[1:0]);
    end
    sync_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    check(sync_seen_out, 1'b0, "sync");
    frame;
    check(sync_seen_out, 1'b1, "sync");
    spi_xfer(1'b0);
    spi_xfer(1'b1);
    $display("sync test done");
    end_sim;
  end
  // a hang counts as a mismatch; a clean run needs about 70000 cycles
  initial
  begin
    #450000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
endmodule // tb_aslo_top
